// File: rtl/mrx_status_cfg.sv
/*
  Per-port receive status capture, status double word builder, interrupt
  combiner and configuration register one, as a classic Wishbone slave.
  Assumes the receive engine, transmit status logic and receive FIFO run on
  the same clock; the abort, chip select, full duplex and transmit clock pins
  are asynchronous and are synchronised here.
*/
// Decided for this implementation: the register offsets and the Wishbone register port.
//
// Notes on behaviour
// R1 - capture status of every frame, even discarded
// R2 - capture clears old flag, then write-protects
// R3 - read returns status, clears it, re-enables
// R4 - status bits zero to six, reset zero
// R5 - bit seven: one old, zero new
// R6 - kept frame gets status plus count word
// R7 - word bit seven: abort while chip deselected
// R8 - word bit eight: written/read dword mismatch
// R9 - reading fault word resets receive section
// R10 - host treats fault-flagged frame data corrupt
// R11 - receive and transmit interrupts share output
// R12 - interrupt is status gated; read clears
// R13 - status word layout ignores byte order
// R14 - config one resets to all zero
// R15 - group mode masks last four address bits
// R16 - config bit zero reads slow transmit clock
// R17 - autopad to sixty bytes, pad 00/55
// R18 - bit two suppresses transmit preamble
// R19 - bit four suppresses transmit fcs
// R20 - bit six keeps received fcs bytes
// R21 - bit seven masks all receive interrupts
// R22 - host avoids match mode change mid-frame
// R23 - full duplex is bit five or pin
// R24 - bit three drops own looped data; the code drops it in half duplex only, not with bit five or the pin set
`timescale 1ns/1ps
module mrx_status_cfg
  import mrx_pkg::*;
#(
  parameter int COUNT_W = 16
)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // receive engine, frame end
  input wire logic rx_frame_end,
  input wire logic [6:0] rx_frame_status,
  input wire logic rx_frame_discard,
  input wire logic [COUNT_W-1:0] rx_byte_count,
  input wire logic rx_dw_written,
  input wire logic rx_dw_read,
  // status double word towards the receive fifo
  output logic [31:0] status_dw,
  output logic status_dw_valid,
  // host pops a status word from the fifo
  input wire logic status_dw_popped,
  input wire logic popped_fault,
  output logic rx_section_reset,
  // asynchronous pins
  input wire logic receive_abort_input,
  input wire logic chip_select_low,
  input wire logic full_duplex_pin,
  input wire logic tx_clock_pin,
  // transmit side
  input wire logic tx_irq_request,
  input wire logic mii_mode,
  // configuration towards the mac
  output logic group_addr_mode,
  output logic [3:0] addr_compare_mask,
  output logic autopad_on,
  output logic [7:0] pad_min_bytes,
  output logic [7:0] pad_byte,
  output logic no_preamble,
  output logic no_fcs,
  output logic rx_fcs_keep,
  output logic full_duplex,
  output logic own_rx_drop,
  // interrupt
  output logic port_irq
);

  // pin synchronisers, first stage read only by second
  // the transmit clock pin is only sampled here, never used as a clock
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end
    else
    begin
      pin_s1_q <= {tx_clock_pin, full_duplex_pin, chip_select_low, receive_abort_input};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic abort_s;
  logic csel_n_s;
  logic fdx_pin_s;
  logic txclk_s;
  assign abort_s = pin_s2_q[0];
  assign csel_n_s = pin_s2_q[1];
  assign fdx_pin_s = pin_s2_q[2];
  assign txclk_s = pin_s2_q[3];

  // wishbone decode
  // writes use lane 0 only; every register here is eight bits or less
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [3:0] ofs;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign bus_rd = bus_req && !wb_we_i;
  // address bits 1:0 are ignored, so any byte address within a word hits
  assign ofs = {wb_adr_i[3:2], 2'b00};

  logic status_rd;
  assign status_rd = bus_rd && (ofs == OFS_RX_STATUS);

  // receive status register
  logic [6:0] rx_stat_q;
  logic stat_old_q;
  logic stat_held_q;
  logic capture;
  assign capture = rx_frame_end && !stat_held_q;
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      rx_stat_q <= RST_RX_STATUS[6:0]; // R4
      stat_old_q <= RST_RX_STATUS[ST_OLD];
      stat_held_q <= 1'b0;
    end
    else if (capture)
    begin
      // a capture in the read cycle wins; a frame ending while status is still held is not captured
      rx_stat_q <= rx_frame_status; // R1
      stat_old_q <= 1'b0; // R2
      stat_held_q <= 1'b1; // R2
    end
    else if (status_rd)
    begin
      rx_stat_q <= 7'h00; // R3
      stat_old_q <= 1'b1; // R5
      stat_held_q <= 1'b0; // R3
    end
  end

  // abort seen while chip deselected, per frame
  logic abort_d1_q;
  logic frame_abort_q;
  logic abort_edge;
  // abort counts only while the chip is deselected
  assign abort_edge = abort_s && !abort_d1_q && csel_n_s;
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      abort_d1_q <= 1'b0;
      frame_abort_q <= 1'b0;
    end
    else
    begin
      abort_d1_q <= abort_s;
      if (abort_edge)
        frame_abort_q <= 1'b1; // R7
      else if (rx_frame_end || rx_section_reset)
        frame_abort_q <= 1'b0;
    end
  end

  // dword bookkeeping for the fifo fault check
  // counts restart at every frame end, so one fault never spills over
  logic [COUNT_W-1:0] dw_wr_cnt_q;
  logic [COUNT_W-1:0] dw_rd_cnt_q;
  logic [COUNT_W-1:0] dw_expected;
  logic fifo_fault;
  assign dw_expected = (rx_byte_count + COUNT_W'(3)) >> 2;
  assign fifo_fault = (dw_wr_cnt_q != dw_expected) || (dw_rd_cnt_q != dw_wr_cnt_q); // R8

  always_ff @(posedge clock)
  begin
    if (!resetn || rx_frame_end || rx_section_reset)
    begin
      dw_wr_cnt_q <= '0;
      dw_rd_cnt_q <= '0;
    end
    else
    begin
      if (rx_dw_written)
        dw_wr_cnt_q <= dw_wr_cnt_q + COUNT_W'(1);
      if (rx_dw_read)
        dw_rd_cnt_q <= dw_rd_cnt_q + COUNT_W'(1);
    end
  end

  // status double word; same layout in either byte order
  logic [31:0] status_dw_d;
  logic kept_end;
  assign kept_end = rx_frame_end && !rx_frame_discard;
  always_comb
  begin
    status_dw_d = 32'h0000_0000; // R13
    status_dw_d[6:0] = rx_frame_status; // R6
    // word bit seven carries the abort flag, not the old/new flag
    // an abort edge in the end cycle still belongs to this frame
    status_dw_d[SDW_ABORT] = frame_abort_q || abort_edge; // R7
    status_dw_d[SDW_FAULT] = fifo_fault; // R8
    status_dw_d[SDW_COUNT_LSB +: 16] = 16'(rx_byte_count); // R6
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      status_dw <= 32'h0000_0000;
      status_dw_valid <= 1'b0;
    end
    else
    begin
      status_dw_valid <= kept_end; // R6
      if (kept_end)
        status_dw <= status_dw_d; // R6
    end
  end

  // fault word read restarts reception cleanly
  always_ff @(posedge clock)
  begin
    if (!resetn)
      rx_section_reset <= 1'b0;
    else
      rx_section_reset <= status_dw_popped && popped_fault; // R9
  end

  // configuration register one and receive interrupt enables
  // the enables gate only the interrupt, never what is captured
  logic [7:0] cfg_q;
  logic [5:0] irq_en_q;
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cfg_q <= RST_CONFIG_ONE; // R14
      irq_en_q <= RST_RX_IRQ_EN;
    end
    else if (bus_wr)
    begin
      if (ofs == OFS_CONFIG_ONE)
        cfg_q <= wb_dat_i[7:0];
      if (ofs == OFS_RX_IRQ_EN)
        irq_en_q <= wb_dat_i[5:0];
    end
  end

  // transmit clock rate: long gaps between edges mean the slow rate
  // the gap saturates rather than wrapping back to a short count
  logic txclk_d1_q;
  logic [7:0] txclk_gap_q;
  logic txclk_slow_q;
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      txclk_d1_q <= 1'b0;
      txclk_gap_q <= 8'h00;
      txclk_slow_q <= 1'b0;
    end
    else
    begin
      txclk_d1_q <= txclk_s;
      if (txclk_s && !txclk_d1_q)
      begin
        txclk_slow_q <= (txclk_gap_q >= 8'(TXCLK_SLOW_CYC)); // R16
        txclk_gap_q <= 8'h00;
      end
      else if (txclk_gap_q != 8'hFF)
        txclk_gap_q <= txclk_gap_q + 8'h01;
    end
  end

  // register read data, registered with the ack
  // unmapped bits read zero; writes to read-only words are dropped
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (ofs)
      OFS_RX_STATUS: rd_data[7:0] = {stat_old_q, rx_stat_q}; // R5
      OFS_CONFIG_ONE: rd_data[7:0] = {cfg_q[7:1], txclk_slow_q}; // R16
      OFS_RX_IRQ_EN: rd_data[5:0] = irq_en_q;
      OFS_PORT_STATE: rd_data[3:0] = {full_duplex, stat_held_q, fdx_pin_s, txclk_slow_q};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_rd)
        wb_dat_o <= rd_data;
    end
  end

  // interrupt combining; status only counts while unread
  // the transmit request arrives already gated by its own enables
  logic [5:0] rx_irq_src;
  logic rx_irq;
  assign rx_irq_src = {rx_stat_q[ST_GOOD], rx_stat_q[ST_FIRST12], rx_stat_q[ST_SHORT],
    rx_stat_q[ST_OVERSIZE], rx_stat_q[ST_CRC_ERR], rx_stat_q[ST_OVERFLOW]};
  assign rx_irq = stat_held_q && |(rx_irq_src & irq_en_q) && !cfg_q[CF_RX_IRQ_OFF]; // R21

  always_ff @(posedge clock)
  begin
    if (!resetn)
      port_irq <= 1'b0;
    else
      port_irq <= rx_irq || tx_irq_request; // R11 R12
  end

  // configuration outputs towards the mac
  // registered so the mac sees one clean change per write
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      group_addr_mode <= 1'b0;
      addr_compare_mask <= 4'hF;
      autopad_on <= 1'b0;
      pad_min_bytes <= PAD_MIN_BYTES;
      pad_byte <= PAD_BYTE_SERIAL;
      no_preamble <= 1'b0;
      no_fcs <= 1'b0;
      rx_fcs_keep <= 1'b0;
      full_duplex <= 1'b0;
      own_rx_drop <= 1'b0;
    end
    else
    begin
      group_addr_mode <= cfg_q[CF_GROUP_TXRATE]; // R15
      addr_compare_mask <= cfg_q[CF_GROUP_TXRATE] ? 4'h0 : 4'hF; // R15
      autopad_on <= cfg_q[CF_AUTOPAD]; // R17
      pad_min_bytes <= PAD_MIN_BYTES; // R17
      pad_byte <= mii_mode ? PAD_BYTE_MII : PAD_BYTE_SERIAL; // R17
      no_preamble <= cfg_q[CF_NO_PREAMBLE]; // R18
      no_fcs <= cfg_q[CF_NO_CRC]; // R19
      rx_fcs_keep <= cfg_q[CF_RX_CRC_KEEP]; // R20
      full_duplex <= cfg_q[CF_FULL_DUPLEX] || fdx_pin_s; // R23
      // half duplex only: in full duplex looped data is real traffic
      own_rx_drop <= cfg_q[CF_OWN_RX_DROP] && !(cfg_q[CF_FULL_DUPLEX] || fdx_pin_s); // R24
    end
  end

endmodule

// File: rtl/mrx_pkg.sv
/*
  Shared constants for the per-port receive status and configuration block:
  register offsets, field positions, reset values and timing figures.
  Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package mrx_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [3:0] OFS_RX_STATUS = 4'h0;
  localparam logic [3:0] OFS_CONFIG_ONE = 4'h4;
  localparam logic [3:0] OFS_RX_IRQ_EN = 4'h8;
  localparam logic [3:0] OFS_PORT_STATE = 4'hC;
  // reset values
  localparam logic [7:0] RST_RX_STATUS = 8'h00;
  localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
  localparam logic [5:0] RST_RX_IRQ_EN = 6'h00;
  // receive status fields
  localparam int ST_OVERFLOW = 0;
  localparam int ST_CRC_ERR = 1;
  localparam int ST_DRIBBLE = 2;
  localparam int ST_SHORT = 3;
  localparam int ST_OVERSIZE = 4;
  localparam int ST_GOOD = 5;
  localparam int ST_FIRST12 = 6;
  localparam int ST_OLD = 7;
  // status double word fields
  localparam int SDW_ABORT = 7;
  localparam int SDW_FAULT = 8;
  localparam int SDW_COUNT_LSB = 16;
  // config one fields
  localparam int CF_GROUP_TXRATE = 0;
  localparam int CF_AUTOPAD = 1;
  localparam int CF_NO_PREAMBLE = 2;
  localparam int CF_OWN_RX_DROP = 3;
  localparam int CF_NO_CRC = 4;
  localparam int CF_FULL_DUPLEX = 5;
  localparam int CF_RX_CRC_KEEP = 6;
  localparam int CF_RX_IRQ_OFF = 7;
  // transmit encapsulation figures
  localparam logic [7:0] PAD_MIN_BYTES = 8'h3C;
  localparam logic [7:0] PAD_BYTE_SERIAL = 8'h00;
  localparam logic [7:0] PAD_BYTE_MII = 8'h55;
  localparam int ADDR_MASK_BITS = 4;
  // transmit clock rate detection
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TXCLK_SLOW_MIN_NS = 300;
  localparam int TXCLK_SLOW_CYC = (TXCLK_SLOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// File: bench/mrx_far.sv
/*
  Transceiver transmit clock for the port under test.
  Assumes the bench selects the slow rate only while it checks rate detection.
*/
`timescale 1ns/1ps
module mrx_far
(
  // rate select
  input wire logic slow_clock,
  // transceiver pin
  output logic tx_clock_pin
);
  initial tx_clock_pin = 1'b0;
  // runs free at 200 ns, or 1000 ns when slow
  always #(slow_clock ? 500 : 100) tx_clock_pin = ~tx_clock_pin;
endmodule

// File: bench/mrx_props.sv
/*
  Concurrent checks on the ports of mrx_status_cfg.
  Assumes a single clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module mrx_props
#(
  parameter int COUNT_W = 16
)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // frame end and status word
  input wire logic rx_frame_end,
  input wire logic rx_frame_discard,
  input wire logic [COUNT_W-1:0] rx_byte_count,
  input wire logic [31:0] status_dw,
  input wire logic status_dw_valid,
  input wire logic status_dw_popped,
  input wire logic popped_fault,
  input wire logic rx_section_reset,
  // configuration and interrupt
  input wire logic mii_mode,
  input wire logic [7:0] pad_byte,
  input wire logic [7:0] pad_min_bytes,
  input wire logic group_addr_mode,
  input wire logic [3:0] addr_compare_mask,
  input wire logic tx_irq_request,
  input wire logic port_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence word_pulse;
    ##1 status_dw_valid ##1 !status_dw_valid;
  endsequence
  sequence reset_pulse;
    ##1 rx_section_reset ##1 !rx_section_reset;
  endsequence
  ack_one_cycle_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");
  kept_word_a: assert property (
    rx_frame_end && !rx_frame_discard |-> word_pulse)
    else $error("kept frame without status word");
  dropped_word_a: assert property (
    rx_frame_end && rx_frame_discard |=> !status_dw_valid)
    else $error("dropped frame got status word");
  word_count_a: assert property (
    status_dw_valid |-> status_dw[31:16] == $past(rx_byte_count[15:0]) && status_dw[15:9] == 0)
    else $error("status word layout wrong");
  fault_reset_a: assert property (
    status_dw_popped && popped_fault |-> reset_pulse)
    else $error("fault pop without section reset");
  group_mask_a: assert property (
    addr_compare_mask == (group_addr_mode ? 4'h0 : 4'hF))
    else $error("address mask wrong");
  pad_value_a: assert property (
    pad_min_bytes == 8'h3C && pad_byte == ($past(mii_mode) ? 8'h55 : 8'h00))
    else $error("pad settings wrong");
  tx_irq_merge_a: assert property (
    $past(tx_irq_request) |-> port_irq)
    else $error("transmit request not on port interrupt");
endmodule
bind mrx_status_cfg mrx_props #(.COUNT_W(COUNT_W)) mrx_props_i (.clock, .resetn, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .rx_frame_end, .rx_frame_discard, .rx_byte_count, .status_dw,
  .status_dw_valid, .status_dw_popped, .popped_fault, .rx_section_reset, .mii_mode, .pad_byte,
  .pad_min_bytes, .group_addr_mode, .addr_compare_mask, .tx_irq_request, .port_irq);

// File: bench/tb.sv
/*
  Self-checking bench for mrx_status_cfg over classic Wishbone.
  Assumes mrx_far drives the transmit clock pin; sel is tied to all lanes.
*/
`timescale 1ns/1ps
module tb;
  import mrx_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic rx_frame_end = 1'b0, rx_frame_discard = 1'b0, rx_dw_written = 1'b0, rx_dw_read = 1'b0;
  logic status_dw_popped = 1'b0, popped_fault = 1'b0, receive_abort_input = 1'b0;
  logic chip_select_low = 1'b0, full_duplex_pin = 1'b0, tx_irq_request = 1'b0;
  logic mii_mode = 1'b0, slow_clock = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [6:0] rx_frame_status = 7'h00;
  logic [15:0] rx_byte_count = 16'h0000;
  logic [31:0] wb_dat_o, status_dw, dwq, q;
  logic wb_ack_o, status_dw_valid, rx_section_reset, tx_clock_pin, dwv, port_irq;
  logic group_addr_mode, autopad_on, no_preamble, no_fcs, rx_fcs_keep, full_duplex, own_rx_drop;
  logic [3:0] addr_compare_mask;
  logic [7:0] pad_min_bytes, pad_byte;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  mrx_far mrx_far_i (.slow_clock, .tx_clock_pin);
  mrx_status_cfg mrx_status_cfg_i (.clock, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_frame_end, .rx_frame_status,
    .rx_frame_discard, .rx_byte_count, .rx_dw_written, .rx_dw_read, .status_dw,
    .status_dw_valid, .status_dw_popped, .popped_fault, .rx_section_reset,
    .receive_abort_input, .chip_select_low, .full_duplex_pin, .tx_clock_pin, .tx_irq_request,
    .mii_mode, .group_addr_mode, .addr_compare_mask, .autopad_on, .pad_min_bytes, .pad_byte,
    .no_preamble, .no_fcs, .rx_fcs_keep, .full_duplex, .own_rx_drop, .port_irq);
  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until ack is sampled, then released for a cycle
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clock);
    while (wb_ack_o !== 1'b1) @(posedge clock);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, q, e);
  endtask
  task frame(input logic [6:0] s, input logic [15:0] c, input int nw, input int nr, input logic d);
    for (int i = 0; i < nw; i++)
    begin
      rx_dw_written <= (i < nw);
      rx_dw_read <= (i < nr);
      @(posedge clock);
    end
    rx_dw_written <= 1'b0;
    rx_dw_read <= 1'b0;
    rx_frame_end <= 1'b1;
    rx_frame_status <= s;
    rx_byte_count <= c;
    rx_frame_discard <= d;
    @(posedge clock);
    rx_frame_end <= 1'b0;
    @(negedge clock);
    dwv = status_dw_valid;
    dwq = status_dw;
    @(posedge clock);
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd(OFS_RX_STATUS, 32'h0000_0000, "status");
    rd(OFS_CONFIG_ONE, 32'h0000_0000, "config");
    $display("test reset done");
    frame(7'h21, 16'h0040, 16, 16, 1'b0);
    chk("word", dwq, 32'h0040_0021);
    frame(7'h02, 16'h0008, 2, 2, 1'b0);
    rd(OFS_RX_STATUS, 32'h0000_0021, "held");
    rd(OFS_RX_STATUS, 32'h0000_0080, "cleared");
    frame(7'h08, 16'h0008, 2, 2, 1'b1);
    chk("drop", dwv, 32'h0000_0000);
    rd(OFS_RX_STATUS, 32'h0000_0008, "discarded");
    frame(7'h04, 16'h0008, 2, 1, 1'b0);
    chk("fault", dwq, 32'h0008_0104);
    status_dw_popped <= 1'b1;
    popped_fault <= 1'b1;
    @(posedge clock);
    status_dw_popped <= 1'b0;
    popped_fault <= 1'b0;
    @(negedge clock);
    chk("section reset", rx_section_reset, 32'h0000_0001);
    rd(OFS_RX_STATUS, 32'h0000_0004, "after fault");
    chip_select_low <= 1'b1;
    receive_abort_input <= 1'b1;
    repeat (4) @(posedge clock);
    receive_abort_input <= 1'b0;
    repeat (4) @(posedge clock);
    frame(7'h20, 16'h0004, 1, 1, 1'b0);
    chk("abort", dwq, 32'h0004_00A0);
    rd(OFS_RX_STATUS, 32'h0000_0020, "abort status");
    $display("test receive done");
    bus(1'b1, OFS_CONFIG_ONE, 32'h0000_00FF);
    repeat (2) @(posedge clock);
    chk("modes", {addr_compare_mask, group_addr_mode, autopad_on, no_preamble, own_rx_drop,
      no_fcs, full_duplex, rx_fcs_keep}, 32'h0000_0077);
    rd(OFS_CONFIG_ONE, 32'h0000_00FE, "rate");
    bus(1'b1, OFS_CONFIG_ONE, 32'h0000_0008);
    repeat (2) @(posedge clock);
    chk("half drop", own_rx_drop, 32'h0000_0001);
    full_duplex_pin <= 1'b1;
    mii_mode <= 1'b1;
    repeat (5) @(posedge clock);
    chk("pin", {full_duplex, autopad_on, own_rx_drop}, 32'h0000_0004);
    chk("pad", {pad_min_bytes, pad_byte}, 32'h0000_3C55);
    rd(OFS_PORT_STATE, 32'h0000_000A, "state");
    full_duplex_pin <= 1'b0;
    slow_clock <= 1'b1;
    repeat (200) @(posedge clock);
    rd(OFS_CONFIG_ONE, 32'h0000_0009, "slow");
    slow_clock <= 1'b0;
    $display("test config done");
    bus(1'b1, OFS_RX_IRQ_EN, 32'h0000_0020);
    rd(OFS_RX_IRQ_EN, 32'h0000_0020, "enables");
    frame(7'h20, 16'h0004, 1, 1, 1'b0);
    @(posedge clock);
    chk("irq", port_irq, 32'h0000_0001);
    rd(OFS_RX_STATUS, 32'h0000_0020, "irq status");
    @(posedge clock);
    chk("irq clear", port_irq, 32'h0000_0000);
    bus(1'b1, OFS_CONFIG_ONE, 32'h0000_0080);
    frame(7'h20, 16'h0004, 1, 1, 1'b0);
    @(posedge clock);
    chk("irq off", port_irq, 32'h0000_0000);
    tx_irq_request <= 1'b1;
    repeat (2) @(posedge clock);
    chk("tx irq", port_irq, 32'h0000_0001);
    tx_irq_request <= 1'b0;
    $display("test interrupt done");
    give_verdict();
  end
endmodule
